// File: hdl/atc_pkg.sv
package atc_pkg;
   // geometry
   localparam int NUM_CH = 26;
   localparam int NUM_CMP = 4;
   localparam int TRIG_WORDS = 13;
   // register byte offsets
   localparam logic [11:0] OFS_READY_LOW = 12'h000;
   localparam logic [11:0] OFS_READY_HIGH = 12'h004;
   localparam logic [11:0] OFS_TRIG_BASE = 12'h008;
   localparam logic [11:0] OFS_TRIG_END = 12'h03c;
   localparam logic [11:0] OFS_CMP_CTRL = 12'h040;
   localparam logic [11:0] OFS_CMP_MASK = 12'h050;
   localparam logic [11:0] OFS_CMP_LO = 12'h060;
   localparam logic [11:0] OFS_CMP_HI = 12'h070;
   localparam logic [11:0] OFS_IRQ_ALLOW = 12'h080;
   localparam logic [11:0] OFS_SW_TRIG = 12'h084;
   localparam logic [11:0] OFS_RESULT = 12'h100;
   localparam logic [11:0] OFS_RESULT_END = 12'h168;
   // ready status split
   localparam int READY_LOW_BITS = 16;
   localparam int READY_HIGH_BITS = 10;
   // trigger selector fields
   localparam int SEL_EVEN_LSB = 0;
   localparam int SEL_ODD_LSB = 8;
   localparam int SEL_W = 5;
   // comparator control fields
   localparam int CTRL_CHNL_LSB = 8;
   localparam int CTRL_ON_BIT = 7;
   localparam int CTRL_ALLOW_BIT = 6;
   localparam int CTRL_STAT_BIT = 5;
   localparam int CTRL_IN_WINDOW_BIT = 4;
   localparam int CTRL_ABOVE_HIGH_BIT = 3;
   localparam int CTRL_BELOW_HIGH_BIT = 2;
   localparam int CTRL_ABOVE_LOW_BIT = 1;
   localparam int CTRL_BELOW_LOW_BIT = 0;
   // software trigger register bits
   localparam int SW_COMMON_BIT = 0;
   localparam int SW_LEVEL_BIT = 1;
   // trigger source codes
   localparam logic [4:0] TRIG_NONE = 5'h00;
   localparam logic [4:0] TRIG_SW_COMMON = 5'h01;
   localparam logic [4:0] TRIG_SW_LEVEL = 5'h02;
   localparam logic [4:0] TRIG_RESERVED = 5'h03;
   localparam logic [4:0] TRIG_PWM_FIRST = 5'h04;
   localparam logic [4:0] TRIG_CAPTURE_FIRST = 5'h14;
   localparam logic [4:0] TRIG_MULTI_CAPTURE = 5'h1b;
   localparam logic [4:0] TRIG_LOGIC_FIRST = 5'h1c;
   localparam logic [4:0] TRIG_SEQUENCER = 5'h1e;
   localparam logic [4:0] TRIG_EXTERNAL = 5'h1f;
   // reset values
   localparam logic [15:0] RST_WORD = 16'h0000;
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// File: hdl/atc_adc_control.sv
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Notes on behaviour
// R01: one ready flag per channel 0..25
// R02: upper ready word bits 15..10 read zero
// R03: thirteen selector words, two five-bit fields each
// R04: codes 0..3: none, common, level, reserved
// R05: codes 4..19 pick generator triggers ascending
// R06: codes 20..31 capture, logic, sequencer, pin
// R07: four comparators with identical control words
// R08: event records causing channel in bits 12..8
// R09: bit 7 enables; off holds status clear
// R10: bit 6 lets comparator raise common interrupt
// R11: status set on event, cleared reading control word
// R12: bit 4: low <= result < high
// R13: bit 3: result >= high
// R14: bit 2: result < high
// R15: bit 1: result >= low
// R16: bit 0: result < low
// R17: only masked-in channels are compared
// R18: per-channel enable gates channel and common interrupt
// R19: enabled conditions are combined by OR
// R20: reading result buffer clears its ready flag
module atc_adc_control
   import atc_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int DATA_W = 16
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // finished conversions from the converter cores
   input wire logic conv_valid,
   input wire logic [4:0] conv_channel,
   input wire logic [DATA_W-1:0] conv_data,
   // trigger sources
   input wire logic [15:0] pwm_trig,
   input wire logic [6:0] capture_trig,
   input wire logic multi_capture_trig,
   input wire logic [1:0] logic_cell_trig,
   input wire logic trigger_sequencer,
   input wire logic external_trigger_pin,
   // outputs to the converter and interrupt controller
   output logic [NUM_CH-1:0] chan_trigger,
   output logic [NUM_CH-1:0] chan_irq,
   output logic adc_common_irq
);

   function automatic logic atc_mapped(input logic [ADDR_W-1:0] a);
      logic [11:0] w;
      w = 12'(a);
      atc_mapped = (w[1:0] == 2'b00) && ((w < OFS_TRIG_END) ||
                   (w >= OFS_CMP_CTRL && w <= OFS_SW_TRIG) ||
                   (w >= OFS_RESULT && w < OFS_RESULT_END));
   endfunction

   function automatic logic [15:0] atc_merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      atc_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // register state
   logic [NUM_CH-1:0] chan_result_ready;
   logic [DATA_W-1:0] channel_result_buffer [NUM_CH];
   logic [SEL_W-1:0] chan_trigger_source [NUM_CH];
   logic [NUM_CH-1:0] common_irq_allow;
   logic [NUM_CMP-1:0] comparator_on;
   logic [NUM_CMP-1:0] cmp_irq_allow;
   logic [4:0] cmp_conditions [NUM_CMP];
   logic [NUM_CMP-1:0] cmp_stat;
   logic [4:0] event_channel_number [NUM_CMP];
   logic [NUM_CH-1:0] compare_channel_mask [NUM_CMP];
   logic [DATA_W-1:0] compare_low_threshold [NUM_CMP];
   logic [DATA_W-1:0] compare_high_threshold [NUM_CMP];
   logic sw_common_pulse;
   logic sw_level;
   logic ext_meta;
   logic ext_sync;

   // bus handshake state
   logic wr_go;
   logic rd_go;
   logic [11:0] waddr;
   logic [11:0] raddr;
   logic [31:0] next_rdata;
   logic [NUM_CMP-1:0] stat_read_clr;
   logic [NUM_CH-1:0] ready_read_clr;
   logic conv_ok;
   logic [31:0] trig_src;

   assign waddr = 12'(s_axi_awaddr);
   assign raddr = 12'(s_axi_araddr);
   // address and data are taken together, one write in flight
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
   assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
   assign conv_ok = conv_valid && (conv_channel < 5'(NUM_CH));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         s_axi_awready <= wr_go;
         s_axi_wready <= wr_go;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= atc_mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= rd_go;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= atc_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // read mux; reserved bits and unmapped words read as zero
   always_comb begin
      int idx;
      next_rdata = 32'h0000_0000;
      stat_read_clr = '0;
      ready_read_clr = '0;
      idx = 0;
      if (atc_mapped(s_axi_araddr)) begin
         if (raddr == OFS_READY_LOW) begin
            next_rdata[READY_LOW_BITS-1:0] = chan_result_ready[READY_LOW_BITS-1:0]; // R01
         end else if (raddr == OFS_READY_HIGH) begin
            next_rdata[READY_HIGH_BITS-1:0] = chan_result_ready[NUM_CH-1:READY_LOW_BITS]; // R02
         end else if (raddr < OFS_TRIG_END) begin
            idx = int'(raddr - OFS_TRIG_BASE) >> 2;
            next_rdata[SEL_EVEN_LSB +: SEL_W] = chan_trigger_source[2*idx]; // R03
            next_rdata[SEL_ODD_LSB +: SEL_W] = chan_trigger_source[2*idx+1]; // R03
         end else if (raddr < OFS_CMP_MASK) begin
            idx = int'(raddr[3:2]);
            next_rdata[CTRL_CHNL_LSB +: 5] = event_channel_number[idx]; // R08
            next_rdata[CTRL_ON_BIT] = comparator_on[idx];
            next_rdata[CTRL_ALLOW_BIT] = cmp_irq_allow[idx];
            next_rdata[CTRL_STAT_BIT] = cmp_stat[idx];
            next_rdata[4:0] = cmp_conditions[idx];
            stat_read_clr[idx] = rd_go; // R11
         end else if (raddr < OFS_CMP_LO) begin
            next_rdata[NUM_CH-1:0] = compare_channel_mask[raddr[3:2]];
         end else if (raddr < OFS_CMP_HI) begin
            next_rdata[DATA_W-1:0] = compare_low_threshold[raddr[3:2]];
         end else if (raddr < OFS_IRQ_ALLOW) begin
            next_rdata[DATA_W-1:0] = compare_high_threshold[raddr[3:2]];
         end else if (raddr == OFS_IRQ_ALLOW) begin
            next_rdata[NUM_CH-1:0] = common_irq_allow;
         end else if (raddr == OFS_SW_TRIG) begin
            next_rdata[SW_LEVEL_BIT] = sw_level;
         end else begin
            idx = int'(raddr - OFS_RESULT) >> 2;
            next_rdata[DATA_W-1:0] = channel_result_buffer[idx];
            ready_read_clr[idx] = rd_go; // R20
         end
      end
   end

   // software-written configuration
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int c = 0; c < NUM_CH; c++) begin
            chan_trigger_source[c] <= TRIG_NONE;
         end
         for (int x = 0; x < NUM_CMP; x++) begin
            cmp_conditions[x] <= 5'h00;
            compare_channel_mask[x] <= '0;
            compare_low_threshold[x] <= RST_WORD;
            compare_high_threshold[x] <= RST_WORD;
         end
         comparator_on <= '0;
         cmp_irq_allow <= '0;
         common_irq_allow <= '0;
         sw_level <= 1'b0;
         sw_common_pulse <= 1'b0;
      end else begin
         // the common software trigger is a single-cycle strobe
         sw_common_pulse <= 1'b0;
         if (wr_go && atc_mapped(s_axi_awaddr)) begin
            if (waddr >= OFS_TRIG_BASE && waddr < OFS_TRIG_END) begin
               for (int w = 0; w < TRIG_WORDS; w++) begin
                  if (waddr == OFS_TRIG_BASE + 12'(4*w)) begin
                     if (s_axi_wstrb[0]) chan_trigger_source[2*w] <= s_axi_wdata[SEL_EVEN_LSB +: SEL_W]; // R03
                     if (s_axi_wstrb[1]) chan_trigger_source[2*w+1] <= s_axi_wdata[SEL_ODD_LSB +: SEL_W]; // R03
                  end
               end
            end else if (waddr >= OFS_CMP_CTRL && waddr < OFS_CMP_MASK) begin
               // channel number and status are hardware-owned; only the low byte is writable
               if (s_axi_wstrb[0]) begin
                  comparator_on[waddr[3:2]] <= s_axi_wdata[CTRL_ON_BIT]; // R09
                  cmp_irq_allow[waddr[3:2]] <= s_axi_wdata[CTRL_ALLOW_BIT]; // R10
                  cmp_conditions[waddr[3:2]] <= s_axi_wdata[4:0];
               end
            end else if (waddr >= OFS_CMP_MASK && waddr < OFS_CMP_LO) begin
               for (int b = 0; b < NUM_CH; b++) begin
                  if (s_axi_wstrb[b/8]) compare_channel_mask[waddr[3:2]][b] <= s_axi_wdata[b];
               end
            end else if (waddr >= OFS_CMP_LO && waddr < OFS_CMP_HI) begin
               compare_low_threshold[waddr[3:2]] <=
                  atc_merge(compare_low_threshold[waddr[3:2]], s_axi_wdata, s_axi_wstrb);
            end else if (waddr >= OFS_CMP_HI && waddr < OFS_IRQ_ALLOW) begin
               compare_high_threshold[waddr[3:2]] <=
                  atc_merge(compare_high_threshold[waddr[3:2]], s_axi_wdata, s_axi_wstrb);
            end else if (waddr == OFS_IRQ_ALLOW) begin
               for (int b = 0; b < NUM_CH; b++) begin
                  if (s_axi_wstrb[b/8]) common_irq_allow[b] <= s_axi_wdata[b];
               end
            end else if (waddr == OFS_SW_TRIG && s_axi_wstrb[0]) begin
               sw_common_pulse <= s_axi_wdata[SW_COMMON_BIT]; // R04
               sw_level <= s_axi_wdata[SW_LEVEL_BIT]; // R04
            end
         end
      end
   end

   // result buffers and ready flags; a new result beats a same-cycle read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chan_result_ready <= '0;
         for (int c = 0; c < NUM_CH; c++) begin
            channel_result_buffer[c] <= RST_WORD;
         end
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (conv_ok && conv_channel == 5'(c)) begin
               channel_result_buffer[c] <= conv_data;
               chan_result_ready[c] <= 1'b1; // R01
            end else if (ready_read_clr[c]) begin
               chan_result_ready[c] <= 1'b0; // R20
            end
         end
      end
   end

   // external pin is asynchronous to aclk
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
      end else begin
         ext_meta <= external_trigger_pin;
         ext_sync <= ext_meta;
      end
   end

   // source vector laid out by selector code, so the select is a plain index
   always_comb begin
      trig_src = 32'h0000_0000;
      trig_src[TRIG_SW_COMMON] = sw_common_pulse; // R04
      trig_src[TRIG_SW_LEVEL] = sw_level; // R04
      trig_src[TRIG_PWM_FIRST +: 16] = pwm_trig; // R05
      trig_src[TRIG_CAPTURE_FIRST +: 7] = capture_trig; // R06
      trig_src[TRIG_MULTI_CAPTURE] = multi_capture_trig; // R06
      trig_src[TRIG_LOGIC_FIRST +: 2] = logic_cell_trig; // R06
      trig_src[TRIG_SEQUENCER] = trigger_sequencer; // R06
      trig_src[TRIG_EXTERNAL] = ext_sync; // R06
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chan_trigger <= '0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            // codes none and reserved index bits that are held at zero
            chan_trigger[c] <= trig_src[chan_trigger_source[c]]; // R04
         end
      end
   end

   // comparators
   genvar gx;
   generate
      for (gx = 0; gx < NUM_CMP; gx++) begin : g_cmp
         logic [DATA_W-1:0] lo;
         logic [DATA_W-1:0] hi;
         logic [4:0] cond;
         logic hit;
         assign lo = compare_low_threshold[gx];
         assign hi = compare_high_threshold[gx];
         assign cond = cmp_conditions[gx];
         assign hit = comparator_on[gx] && conv_ok && compare_channel_mask[gx][conv_channel] && // R17
            ((cond[CTRL_IN_WINDOW_BIT] && conv_data >= lo && conv_data < hi) || // R12 R19
             (cond[CTRL_ABOVE_HIGH_BIT] && conv_data >= hi) || // R13
             (cond[CTRL_BELOW_HIGH_BIT] && conv_data < hi) || // R14
             (cond[CTRL_ABOVE_LOW_BIT] && conv_data >= lo) || // R15
             (cond[CTRL_BELOW_LOW_BIT] && conv_data < lo)); // R16

         // R07
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               cmp_stat[gx] <= 1'b0;
               event_channel_number[gx] <= 5'h00;
            end else begin
               if (!comparator_on[gx]) begin
                  cmp_stat[gx] <= 1'b0; // R09
               end else if (hit) begin
                  cmp_stat[gx] <= 1'b1; // R11
               end else if (stat_read_clr[gx]) begin
                  cmp_stat[gx] <= 1'b0; // R11
               end
               if (hit) begin
                  event_channel_number[gx] <= conv_channel; // R08
               end
            end
         end
      end
   endgenerate

   // interrupt outputs are levels that follow the flags
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chan_irq <= '0;
         adc_common_irq <= 1'b0;
      end else begin
         chan_irq <= chan_result_ready & common_irq_allow; // R18
         adc_common_irq <= (|(chan_result_ready & common_irq_allow)) || (|(cmp_stat & cmp_irq_allow)); // R10 R18
      end
   end

endmodule // atc_adc_control

// File: verif/atc_adc_control_assertions.sv
`timescale 1ns/100ps
module atc_adc_control_assertions
   import atc_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   // interrupts
   input wire logic [NUM_CH-1:0] chan_irq,
   input wire logic adc_common_irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic rd_go;
   logic wr_go;
   assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
   property p_wr_answer;
      wr_go |=> s_axi_awready && s_axi_wready && s_axi_bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_rd_answer;
      rd_go |=> s_axi_arready && s_axi_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_ready_high;
      rd_go && s_axi_araddr == OFS_READY_HIGH |=> s_axi_rdata[31:10] == '0;
   endproperty
   a_ready_high: assert property (p_ready_high) else $error("upper ready bits set");
   property p_trig_fields;
      rd_go && s_axi_araddr >= OFS_TRIG_BASE && s_axi_araddr <= OFS_TRIG_END
         |=> s_axi_rdata[31:13] == '0 && s_axi_rdata[7:5] == '0;
   endproperty
   a_trig_fields: assert property (p_trig_fields) else $error("selector spare bits set");
   property p_evt_chan;
      rd_go && s_axi_araddr >= OFS_CMP_CTRL && s_axi_araddr < OFS_CMP_MASK
         |=> s_axi_rdata[31:13] == '0 && s_axi_rdata[12:8] < 5'h1a;
   endproperty
   a_evt_chan: assert property (p_evt_chan) else $error("bad event channel");
   property p_common;
      |chan_irq |-> adc_common_irq;
   endproperty
   a_common: assert property (p_common) else $error("channel irq not on common irq");
   property p_unmapped;
      rd_go && s_axi_araddr == 12'h088 |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
   c_evt: cover property (adc_common_irq && !(|chan_irq));
   c_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
   c_wr: cover property (wr_go);
endmodule // atc_adc_control_assertions
bind atc_adc_control atc_adc_control_assertions #(.ADDR_W(ADDR_W)) i_atc_adc_control_assertions (.aclk,
   .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .chan_irq, .adc_common_irq);

// File: verif/atc_conv_model.sv
`timescale 1ns/100ps
module atc_conv_model
   import atc_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // pacing and input level
   input wire logic slow,
   input wire logic [15:0] level,
   // triggers in, results out
   input wire logic [NUM_CH-1:0] chan_trigger,
   output logic conv_valid,
   output logic [4:0] conv_channel,
   output logic [15:0] conv_data
);
   logic [NUM_CH-1:0] pend;
   logic [3:0] cnt;
   logic [4:0] pick;
   logic go;
   always_comb begin
      pick = 5'h00;
      for (int i = NUM_CH - 1; i >= 0; i--)
         if (pend[i]) pick = 5'(i);
   end
   assign go = pend != '0 && cnt >= (slow ? 4'h6 : 4'h0);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend <= '0;
         cnt <= 4'h0;
         conv_valid <= 1'b0;
         conv_channel <= 5'h00;
         conv_data <= 16'h0000;
      end else begin
         // one core: lowest waiting channel first
         pend <= (pend | chan_trigger) & ~(go ? NUM_CH'(1) << pick : '0);
         cnt <= (go || pend == '0) ? 4'h0 : cnt + 4'h1;
         conv_valid <= go;
         // idle lines toggle so stale values never look like a result
         conv_channel <= go ? pick : ~conv_channel;
         conv_data <= go ? level + 16'(pick) : ~conv_data;
      end
   end
endmodule // atc_conv_model

// File: verif/adc_trigger_ready_digital_compare_test.sv
`timescale 1ns/100ps
module adc_trigger_ready_digital_compare_test;
   import atc_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_valid, adc_common_irq;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, src = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [4:0] conv_channel;
   logic [15:0] conv_data, level = 16'h0000;
   logic [NUM_CH-1:0] chan_trigger, chan_irq;
   logic [4:0] evch [NUM_CMP] = '{default: 5'h00};
   int n_errors = 0, checked = 0, nconv = 0;
   initial forever #10 aclk = ~aclk;
   always @(posedge aclk) if (conv_valid) nconv <= nconv + 1;
   atc_adc_control i_atc_adc_control (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .conv_valid, .conv_channel, .conv_data, .pwm_trig(src[19:4]), .capture_trig(src[26:20]),
      .multi_capture_trig(src[27]), .logic_cell_trig(src[29:28]), .trigger_sequencer(src[30]),
      .external_trigger_pin(src[31]), .chan_trigger, .chan_irq, .adc_common_irq);
   atc_conv_model i_atc_conv_model (.aclk, .aresetn, .slow, .level, .chan_trigger, .conv_valid,
      .conv_channel, .conv_data);
   task automatic stop_test();
      if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic tmo();
      n_errors++;
      stop_test();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [11:0] cx(input logic [11:0] b, input int i);
      return b + 12'(4 * i);
   endfunction
   function automatic logic hit(input int b, input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
      case (b)
         5: return v < lo || v >= hi;
         4: return v >= lo && v < hi;
         3: return v >= hi;
         2: return v < hi;
         1: return v >= lo;
         default: return v < lo;
      endcase
   endfunction
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 50) tmo();
      chk(s_axi_bresp, er);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (n == 50) tmo();
      chk(s_axi_rdata & m, e);
      chk(s_axi_rresp, er);
   endtask
   // drive source code k, collect every channel trigger seen meanwhile
   task automatic fire(input int k, output logic [NUM_CH-1:0] m);
      m = '0;
      fork
         begin
            if (k == 1 || k == 2) wr(OFS_SW_TRIG, 32'(k), RESP_OKAY);
            if (k == 2) wr(OFS_SW_TRIG, 32'h0, RESP_OKAY);
            if (k >= 4) begin
               @(posedge aclk);
               src <= 32'h1 << k;
               @(posedge aclk);
               src <= 32'h0;
            end
         end
         repeat (12) begin
            @(posedge aclk);
            m |= chan_trigger;
         end
      join
   endtask
   task automatic conv_wait(input int n0);
      for (int n = 0; n < 40 && nconv == n0; n++) @(posedge aclk);
      if (nconv == n0) tmo();
      repeat (2) @(posedge aclk);
   endtask
   initial begin
      logic [NUM_CH-1:0] m;
      logic [15:0] lo, hi, v;
      logic [7:0] ctl;
      logic h;
      int c, x, nb, n0;
      void'($urandom(69));
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      wr(OFS_READY_LOW, 32'hffff, RESP_OKAY);
      rc(OFS_READY_LOW, 32'hffffffff, 32'h0, RESP_OKAY);
      rc(OFS_READY_HIGH, 32'hffffffff, 32'h0, RESP_OKAY);
      rc(12'h088, 32'hffffffff, 32'h0, RESP_SLVERR);
      rc(12'h002, 32'hffffffff, 32'h0, RESP_SLVERR);
      wr(12'h088, 32'hffff, RESP_SLVERR);
      for (int code = 0; code < 32; code++) begin
         c = $urandom_range(NUM_CH - 1);
         wr(cx(OFS_TRIG_BASE, c / 2), 32'hffffe0e0 | (32'(code) << (c % 2 * 8)), RESP_OKAY);
         rc(cx(OFS_TRIG_BASE, c / 2), 32'hffffffff, 32'(code) << (c % 2 * 8), RESP_OKAY);
         nb = code >= 4 ? code ^ 1 : (code == 1 ? 2 : 1);
         fire(nb, m);
         chk(m[c], 32'h0);
         fire(code, m);
         chk(m[c], code != 0 && code != 3);
         wr(cx(OFS_TRIG_BASE, c / 2), 32'h0, RESP_OKAY);
      end
      for (int b = 0; b < 6; b++) begin
         for (int k = 0; k < 5; k++) begin
            x = $urandom_range(NUM_CMP - 1);
            c = $urandom_range(NUM_CH - 1);
            lo = 16'($urandom);
            hi = 16'($urandom);
            v = k == 0 ? lo : (k == 1 ? hi : 16'($urandom));
            slow <= 1'($urandom_range(1));
            level <= v - 16'(c);
            ctl = (k == 3 ? 8'h40 : (k == 2 && b[0] ? 8'h80 : 8'hc0)) | (b == 5 ? 8'h09 : 8'h01 << b);
            h = k < 3 && hit(b, v, lo, hi);
            wr(cx(OFS_CMP_LO, x), 32'(lo), RESP_OKAY);
            wr(cx(OFS_CMP_HI, x), 32'(hi), RESP_OKAY);
            wr(cx(OFS_CMP_MASK, x), k == 4 ? 32'h0 : 32'h1 << c, RESP_OKAY);
            wr(cx(OFS_CMP_CTRL, x), 32'(ctl), RESP_OKAY);
            wr(cx(OFS_TRIG_BASE, c / 2), 32'(TRIG_SW_COMMON) << (c % 2 * 8), RESP_OKAY);
            n0 = nconv;
            fire(1, m);
            conv_wait(n0);
            chk(adc_common_irq, h && ctl[6]);
            if (h) evch[x] = 5'(c);
            rc(cx(OFS_CMP_CTRL, x), 32'hffffffff, {19'h0, evch[x], ctl[7:6], h, ctl[4:0]}, RESP_OKAY);
            rc(cx(OFS_CMP_CTRL, x), 32'h20, 32'h0, RESP_OKAY);
            rc(cx(OFS_READY_LOW, c / 16), 32'h1 << (c % 16), 32'h1 << (c % 16), RESP_OKAY);
            rc(cx(OFS_RESULT, c), 32'hffffffff, 32'(v), RESP_OKAY);
            rc(cx(OFS_READY_LOW, c / 16), 32'h1 << (c % 16), 32'h0, RESP_OKAY);
            wr(cx(OFS_CMP_CTRL, x), 32'h0, RESP_OKAY);
            wr(cx(OFS_TRIG_BASE, c / 2), 32'h0, RESP_OKAY);
         end
      end
      wr(OFS_IRQ_ALLOW, 32'h1 << 25, RESP_OKAY);
      wr(cx(OFS_TRIG_BASE, 12), 32'(TRIG_SW_COMMON) << 8, RESP_OKAY);
      n0 = nconv;
      fire(1, m);
      conv_wait(n0);
      chk(32'(chan_irq), 32'h1 << 25);
      chk(adc_common_irq, 32'h1);
      rc(cx(OFS_RESULT, 25), 32'hffffffff, 16'(level + 16'h19), RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(32'(chan_irq), 32'h0);
      s_axi_wstrb <= 4'h1;
      wr(OFS_IRQ_ALLOW, 32'h3ffffff, RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      rc(OFS_IRQ_ALLOW, 32'hffffffff, 32'h20000ff, RESP_OKAY);
      stop_test();
   end
endmodule // adc_trigger_ready_digital_compare_test
